/* hw/fqt_pkg.sv */
// Purpose: Shared constants, types and the query table image for the flash query block.
// Assumes: One 8-bit table entry per 32-bit word address.
// Notes:   The command codes are kept here so that host and device agree on them.
package fqt_pkg;

   // ******************************************************************
   // Widths
   // ******************************************************************
   localparam int unsigned ADDR_W  = 19;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned BYTE_W  = 8;
   localparam int unsigned TBL_AW  = 6;
   localparam int unsigned WIDTH_W = 2;

   // ******************************************************************
   // Commands and access widths
   // ******************************************************************
   localparam logic [BYTE_W-1:0]  CMD_QUERY      = 8'h98;
   localparam logic [BYTE_W-1:0]  CMD_READ_ARRAY = 8'hff;
   localparam logic [WIDTH_W-1:0] WID_WORD32     = 2'h0;
   localparam logic [WIDTH_W-1:0] WID_HALF16     = 2'h1;
   localparam logic [WIDTH_W-1:0] WID_BYTE8      = 2'h2;

   // ******************************************************************
   // Table layout and reset values
   // ******************************************************************
   localparam logic [ADDR_W-1:0] TBL_LAST       = 19'h0003f;
   localparam logic [BYTE_W-1:0] ENTRY_ZERO     = 8'h00;
   localparam logic [TBL_AW-1:0] OFF_MANUF      = 6'h00;
   localparam logic [TBL_AW-1:0] OFF_DEVICE     = 6'h01;
   localparam logic [ADDR_W-1:0] ADDR_RST       = 19'h00000;
   localparam logic [DATA_W-1:0] DATA_RST       = 32'h00000000;
   localparam logic [15:0]       COUNT_RST      = 16'h0000;
   localparam logic [15:0]       COUNT_ONE      = 16'h0001;

   // ******************************************************************
   // Types
   // ******************************************************************
   typedef enum logic [0:0] {
      FQT_MODE_ARRAY = 1'b0,
      FQT_MODE_QUERY = 1'b1
   } fqt_mode_t;

   typedef enum logic [1:0] {
      FQT_RD_IDLE  = 2'b00,
      FQT_RD_FETCH = 2'b01,
      FQT_RD_SEND  = 2'b11
   } fqt_rd_state_t;

   typedef struct packed {
      logic                  valid;
      logic [BYTE_W-1:0]     code;
   } fqt_cmd_t;

   typedef struct packed {
      logic                  valid;
      logic [WIDTH_W-1:0]    width;
      logic [ADDR_W-1:0]     addr;
   } fqt_rd_req_t;

   typedef struct packed {
      logic                  valid;
      logic                  refused;
      logic [DATA_W-1:0]     data;
   } fqt_rd_rsp_t;

   // ******************************************************************
   // Fixed table image; identity entries are filled by the memory
   // ******************************************************************
   function automatic logic [BYTE_W-1:0] fqt_image(input logic [TBL_AW-1:0] off);
      logic [BYTE_W-1:0] v;
      v = ENTRY_ZERO;
      unique case (off)
         6'h10: v = 8'h51;
         6'h11: v = 8'h52;
         6'h12: v = 8'h59;
         6'h13: v = 8'h03;
         6'h14: v = 8'h00;
         6'h15: v = 8'h35;
         6'h16: v = 8'h00;
         6'h17, 6'h18, 6'h19, 6'h1a: v = 8'h00;
         6'h1b: v = 8'h27;
         6'h1c: v = 8'h36;
         6'h1d: v = 8'hb4;
         6'h1e: v = 8'hc6;
         6'h1f: v = 8'h04;
         6'h20: v = 8'h00;
         6'h21: v = 8'h0a;
         6'h22: v = 8'h00;
         6'h23, 6'h24: v = 8'h00;
         6'h25: v = 8'h04;
         6'h26: v = 8'h00;
         6'h27: v = 8'h15;
         6'h28: v = 8'h03;
         6'h29, 6'h2a, 6'h2b: v = 8'h00;
         6'h2c: v = 8'h02;
         6'h2d: v = 8'h1e;
         6'h2e, 6'h2f: v = 8'h00;
         6'h30: v = 8'h01;
         6'h31: v = 8'h07;
         6'h32: v = 8'h00;
         6'h33: v = 8'h20;
         6'h34: v = 8'h00;
         6'h35: v = 8'h50;
         6'h36: v = 8'h52;
         6'h37: v = 8'h49;
         6'h38, 6'h39: v = 8'h31;
         6'h3a: v = 8'h86;
         6'h3b: v = 8'h01;
         6'h3c, 6'h3d: v = 8'h00;
         6'h3e: v = 8'h01;
         6'h3f: v = 8'h00;
         default: v = ENTRY_ZERO;
      endcase
      return v;
   endfunction

endpackage

/* hw/fqt_table_rom.sv */
// Purpose: Query table memory with a registered read port.
// Assumes: Identity bytes come from the parent as parameters.
// Notes:   One cycle from address to data.
`timescale 1ns/10ps
module fqt_table_rom
   import fqt_pkg::*;
#(
   parameter logic [BYTE_W-1:0] MANUF_CODE  = 8'h5a,
   parameter logic [BYTE_W-1:0] DEVICE_CODE = 8'ha5
)
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire logic [TBL_AW-1:0] rd_addr,
   output logic      [BYTE_W-1:0] rd_data_reg
);

   logic [BYTE_W-1:0] rd_data_next;

   always_comb
   begin
      rd_data_next = fqt_image(rd_addr);
      if (rd_addr == OFF_MANUF)
      begin
         rd_data_next = MANUF_CODE;
      end
      else if (rd_addr == OFF_DEVICE)
      begin
         rd_data_next = DEVICE_CODE;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_data_reg <= ENTRY_ZERO;
      end
      else
      begin
         rd_data_reg <= rd_data_next;
      end
   end

endmodule

/* hw/fqt_query_top.sv */
// Contract
// - The query command switches reads from array data to the query table.
// - Query reads put the table byte on bits 7-0, upper 24 bits zero.
// - Only 32-bit word addressing of the table; byte and half-word refused.
// - Offsets 10h-12h return 51h, 52h, 59h.
// - Offsets 13h, 14h return command-set identifier 03h then 00h.
// - Offsets 15h, 16h return extended table pointer 35h then 00h.
// - Offsets 17h through 1Ah return 00h, no alternate set.
// - Offsets 1Bh, 1Ch return core supply limits 27h and 36h.
// - Offsets 1Dh, 1Eh return program supply limits B4h and C6h.
// - Offsets 1Fh-22h return typical time-out exponents 04h, 00h, 0Ah, 00h.
// - 23h-24h reserved; 25h returns 04h, 26h returns 00h.
// - Geometry 27h-2Bh returns 15h, 03h, 00h, 00h, 00h.
// - Offset 2Ch returns 02h erase-block regions.
// - First region 2Dh-30h returns 1Eh, 00h, 00h, 01h.
// - Second region 31h-34h returns 07h, 00h, 20h, 00h.
// - Extended table 35h-37h returns 50h, 52h, 49h, then version bytes.
// - Offset 3Ah returns 86h optional-feature byte.
// - Offset 3Bh returns 01h; 3Ch and 3Dh return 00h.
// - Offset 3Eh returns 01h; 3Fh reserved.
//
// Purpose: Query mode control and read path of a 32-bit flash query table.
// Assumes: All inputs come from logic on the same clock.
// Notes:   Read answers two cycles after the request; reads pipeline back to back.
`timescale 1ns/10ps
module fqt_query_top
   import fqt_pkg::*;
#(
   parameter logic [BYTE_W-1:0] MANUF_CODE  = 8'h5a,
   parameter logic [BYTE_W-1:0] DEVICE_CODE = 8'ha5
)
(
   input  wire logic              clock,
   input  wire logic              rst_b,
   input  wire fqt_cmd_t          cmd_in,
   input  wire fqt_rd_req_t       rd_req,
   input  wire logic [DATA_W-1:0] array_data,
   input  wire logic              err_clear,
   output fqt_rd_rsp_t            rd_rsp_reg,
   output logic                   query_mode_reg,
   output logic                   width_err_reg,
   output logic [ADDR_W-1:0]      last_addr_reg,
   output logic [15:0]            query_reads_reg
);

   // ******************************************************************
   // Mode control
   // ******************************************************************
   fqt_mode_t mode_reg;
   fqt_mode_t mode_next;

   always_comb
   begin
      mode_next = mode_reg;
      if (cmd_in.valid)
      begin
         if (cmd_in.code == CMD_QUERY)
         begin
            mode_next = FQT_MODE_QUERY;
         end
         else if (cmd_in.code == CMD_READ_ARRAY)
         begin
            mode_next = FQT_MODE_ARRAY;
         end
      end
   end

   // Other commands leave the mode alone; only read-array ends query mode
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         mode_reg <= FQT_MODE_ARRAY;
      end
      else
      begin
         mode_reg <= mode_next;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         query_mode_reg <= 1'b0;
      end
      else
      begin
         query_mode_reg <= (mode_next == FQT_MODE_QUERY);
      end
   end

   // ******************************************************************
   // Request check
   // ******************************************************************
   logic req_query;
   logic req_refused;
   logic req_in_table;

   // A read is served in the mode that stands when it arrives
   assign req_query    = rd_req.valid && (mode_reg == FQT_MODE_QUERY);
   assign req_refused  = req_query && (rd_req.width != WID_WORD32);
   assign req_in_table = (rd_req.addr <= TBL_LAST);

   // ******************************************************************
   // Table memory
   // ******************************************************************
   logic [BYTE_W-1:0] tbl_byte;

   fqt_table_rom #(
      .MANUF_CODE  (MANUF_CODE),
      .DEVICE_CODE (DEVICE_CODE)
   ) u_rom (
      .clock       (clock),
      .rst_b       (rst_b),
      .rd_addr     (rd_req.addr[TBL_AW-1:0]),
      .rd_data_reg (tbl_byte)
   );

   // ******************************************************************
   // Fetch stage
   // ******************************************************************
   fqt_rd_state_t     rd_state_reg;
   fqt_rd_state_t     rd_state_next;
   logic              f_query_reg;
   logic              f_refused_reg;
   logic              f_in_table_reg;
   logic [DATA_W-1:0] f_array_reg;

   always_comb
   begin
      rd_state_next = FQT_RD_IDLE;
      if (rd_req.valid)
      begin
         rd_state_next = FQT_RD_FETCH;
      end
      else if (rd_state_reg == FQT_RD_FETCH)
      begin
         rd_state_next = FQT_RD_SEND;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_state_reg <= FQT_RD_IDLE;
      end
      else
      begin
         rd_state_reg <= rd_state_next;
      end
   end

   logic fetch_live;

   // Fetch holds a request whenever one was taken on the previous edge
   assign fetch_live = (rd_state_reg == FQT_RD_FETCH);

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         f_query_reg    <= 1'b0;
         f_refused_reg  <= 1'b0;
         f_in_table_reg <= 1'b0;
         f_array_reg    <= DATA_RST;
      end
      else if (rd_req.valid)
      begin
         f_query_reg    <= req_query;
         f_refused_reg  <= req_refused;
         f_in_table_reg <= req_in_table;
         f_array_reg    <= array_data;
      end
   end

   // ******************************************************************
   // Answer stage
   // ******************************************************************
   fqt_rd_rsp_t rsp_next;

   always_comb
   begin
      rsp_next         = '0;
      rsp_next.valid   = fetch_live;
      rsp_next.refused = fetch_live && f_refused_reg;
      if (!fetch_live)
      begin
         rsp_next.data = DATA_RST;
      end
      else if (!f_query_reg)
      begin
         rsp_next.data = f_array_reg;
      end
      else if (f_refused_reg || !f_in_table_reg)
      begin
         // Refused or past the table: an all-zero word, never array data
         rsp_next.data = DATA_RST;
      end
      else
      begin
         rsp_next.data = {{(DATA_W-BYTE_W){1'b0}}, tbl_byte};
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_rsp_reg <= '0;
      end
      else
      begin
         rd_rsp_reg <= rsp_next;
      end
   end

   // ******************************************************************
   // Status
   // ******************************************************************
   // Set wins over clear so a refusal in the clearing cycle is kept
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         width_err_reg <= 1'b0;
      end
      else if (req_refused)
      begin
         width_err_reg <= 1'b1;
      end
      else if (err_clear)
      begin
         width_err_reg <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         last_addr_reg <= ADDR_RST;
      end
      else if (req_query && !req_refused)
      begin
         last_addr_reg <= rd_req.addr;
      end
   end

   // Saturates instead of wrapping so a long session never reads as few
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         query_reads_reg <= COUNT_RST;
      end
      else if (req_query && !req_refused && (query_reads_reg != 16'hffff))
      begin
         query_reads_reg <= query_reads_reg + COUNT_ONE;
      end
   end

endmodule

/* testbench/fqt_query_monitor.sv */
// Purpose: Port checks for the query block.
// Assumes: One clock, active-low asynchronous reset.
// Notes:   Bound from the testbench top file.
`timescale 1ns/10ps
module fqt_query_monitor
   import fqt_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_b,
   input wire fqt_cmd_t          cmd_in,
   input wire fqt_rd_req_t       rd_req,
   input wire logic [DATA_W-1:0] array_data,
   input wire logic              err_clear,
   input wire fqt_rd_rsp_t       rd_rsp_reg,
   input wire logic              query_mode_reg,
   input wire logic              width_err_reg,
   input wire logic [ADDR_W-1:0] last_addr_reg,
   input wire logic [15:0]       query_reads_reg
);
   // ******************************************************************
   // Checks
   // ******************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   logic qrd;
   logic qword;
   assign qrd   = rd_req.valid && query_mode_reg;
   assign qword = qrd && (rd_req.width == WID_WORD32);

   rsp_latency_a: assert property (rd_req.valid |-> ##2 rd_rsp_reg.valid)
      else $error("read answer missing two cycles after request");
   query_enter_a: assert property (cmd_in.valid && cmd_in.code == CMD_QUERY |=> query_mode_reg)
      else $error("query command did not enter query mode");
   mode_hold_a: assert property
      (query_mode_reg && !(cmd_in.valid && cmd_in.code == CMD_READ_ARRAY) |=> query_mode_reg)
      else $error("query mode left without read-array command");
   mode_exit_a: assert property
      (cmd_in.valid && cmd_in.code == CMD_READ_ARRAY |=> !query_mode_reg)
      else $error("read-array command did not leave query mode");
   upper_zero_a: assert property (qrd |-> ##2 rd_rsp_reg.data[31:8] == 24'h000000)
      else $error("upper lanes not zero on query read");
   width_refuse_a: assert property
      (qrd && !qword |-> ##1 width_err_reg ##1 (rd_rsp_reg.refused && rd_rsp_reg.data == 32'h0))
      else $error("narrow query read not refused");
   err_sticky_a: assert property (width_err_reg && !err_clear |=> width_err_reg)
      else $error("width error dropped without clear");
   array_pass_a: assert property
      (rd_req.valid && !query_mode_reg |-> ##2 rd_rsp_reg.data == $past(array_data, 2))
      else $error("array read data wrong");
   id_string_a: assert property (qword && rd_req.addr == 19'h00010 |-> ##2 rd_rsp_reg.data == 32'h51)
      else $error("first identification byte wrong");
   read_count_a: assert property (qword |=> last_addr_reg == $past(rd_req.addr) &&
      query_reads_reg == ($past(query_reads_reg) == 16'hffff ? 16'hffff : $past(query_reads_reg) + 16'h1))
      else $error("query read count or address not updated");

   cover property (qword ##2 rd_rsp_reg.valid);
   cover property (qrd && !qword);
   cover property (rd_req.valid && !query_mode_reg);
   cover property ($fell(query_mode_reg));
endmodule

/* testbench/fqt_host_model.sv */
// Purpose: Host side that issues commands and pipelined reads.
// Assumes: Signals change on the falling edge.
// Notes:   Released lines carry inverted junk; burst inverts them twice, so its lines end on the last value.
`timescale 1ns/10ps
module fqt_host_model
   import fqt_pkg::*;
(
   input  wire logic        clock,
   input  wire fqt_rd_rsp_t rd_rsp_reg,
   output fqt_cmd_t          cmd_in,
   output fqt_rd_req_t       rd_req,
   output logic [DATA_W-1:0] array_data,
   output logic              err_clear
);
   fqt_rd_req_t       reqs [64];
   logic [DATA_W-1:0] arr  [64];
   fqt_rd_rsp_t       rsps [64];

   initial
   begin
      cmd_in     = '0;
      rd_req     = '0;
      array_data = 32'h0;
      err_clear  = 1'b0;
   end

   task automatic send_cmd(input logic [BYTE_W-1:0] code);
      @(negedge clock);
      cmd_in = '{valid:1'b1, code:code};
      @(negedge clock);
      cmd_in = '{valid:1'b0, code:~code};
   endtask

   task automatic clear_err;
      @(negedge clock);
      err_clear = 1'b1;
      @(negedge clock);
      err_clear = 1'b0;
   endtask

   // One request a cycle; answer of request i caught two cycles on
   task automatic burst(input int n);
      for (int i = 0; i < n + 2; i++)
      begin
         @(negedge clock);
         if (i >= 2)
            rsps[i-2] = rd_rsp_reg;
         if (i < n)
         begin
            rd_req     = reqs[i];
            array_data = arr[i];
         end
         else
         begin
            rd_req     = '{valid:1'b0, width:~rd_req.width, addr:~rd_req.addr};
            array_data = ~array_data;
         end
      end
   endtask
endmodule

/* testbench/testbench.sv */
// Purpose: Self-checking bench for the query block.
// Assumes: Seeded random stimulus on the falling edge.
// Notes:   Expected table kept here, independent of the design.
`timescale 1ns/10ps
module testbench
   import fqt_pkg::*;
;
   // ******************************************************************
   // Setup
   // ******************************************************************
   localparam logic [7:0] MAN_CODE = 8'h3c; // Arbitrary value
   localparam logic [7:0] DEV_CODE = 8'hc3; // Arbitrary value
   localparam logic [0:47][7:0] TBL = 384'h51525903003500000000002736b4c604_000a00000004001503000000021e0000_01070020005052493131860100000100;
   logic              clock;
   logic              rst_b;
   fqt_cmd_t          cmd_in;
   fqt_rd_req_t       rd_req;
   logic [DATA_W-1:0] array_data;
   logic              err_clear;
   fqt_rd_rsp_t       rd_rsp_reg;
   logic              query_mode_reg;
   logic              width_err_reg;
   logic [ADDR_W-1:0] last_addr_reg;
   logic [15:0]       query_reads_reg;
   int                err_count = 0;
   int                compares = 0;
   int                cycles = 0;

   fqt_query_top #(.MANUF_CODE(MAN_CODE), .DEVICE_CODE(DEV_CODE)) fqt_query_top_i (.clock,
      .rst_b, .cmd_in, .rd_req, .array_data, .err_clear, .rd_rsp_reg, .query_mode_reg,
      .width_err_reg, .last_addr_reg, .query_reads_reg);
   fqt_host_model fqt_host_model_i (.clock, .rd_rsp_reg, .cmd_in, .rd_req, .array_data,
      .err_clear);

   always #50 clock = ~clock;
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         err_count++;
         tally_and_finish();
      end
   end

   function automatic logic [31:0] exp_word(input logic [ADDR_W-1:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == 19'h0)
         v = MAN_CODE;
      else if (a == 19'h1)
         v = DEV_CODE;
      else if (a >= 19'h10 && a <= TBL_LAST)
         v = TBL[int'(a) - 16];
      return {24'h000000, v};
   endfunction

   task automatic chk_val(input logic [33:0] got, input logic [33:0] exp, input string what);
      compares++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_rsp(input fqt_rd_rsp_t got, input logic rf, input logic [31:0] d);
      chk_val(got, {1'b1, rf, d}, "read answer");
   endtask

   // Query answers for one span of the table, word addressed
   task automatic chk_span(input int lo, input int hi);
      for (int i = lo; i <= hi; i++)
         chk_rsp(fqt_host_model_i.rsps[i], 1'b0, exp_word(19'(i)));
   endtask

   task automatic array_burst(input int n);
      for (int i = 0; i < n; i++)
      begin
         fqt_host_model_i.reqs[i] = '{1'b1, 2'($urandom_range(2)), 19'($urandom)};
         fqt_host_model_i.arr[i] = $urandom;
      end
      fqt_host_model_i.burst(n);
      for (int i = 0; i < n; i++)
         chk_rsp(fqt_host_model_i.rsps[i], 1'b0, fqt_host_model_i.arr[i]);
   endtask

   task automatic tally_and_finish;
      if (err_count == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ******************************************************************
   // Scenarios
   // ******************************************************************
   initial
   begin
      clock = 1'b0;
      rst_b = 1'b0;
      void'($urandom(95994));
      repeat (3) @(posedge clock);
      @(negedge clock);
      rst_b = 1'b1;
      chk_val(query_mode_reg, 0, "mode after reset");
      array_burst(8);
      fqt_host_model_i.send_cmd(CMD_QUERY);
      chk_val(query_mode_reg, 1, "query mode");
      // Random array data alongside: a query answer must never carry it
      for (int i = 0; i < 64; i++)
      begin
         fqt_host_model_i.reqs[i] = '{1'b1, WID_WORD32, 19'(i)};
         fqt_host_model_i.arr[i] = $urandom;
      end
      fqt_host_model_i.burst(64);
      chk_span(0, 15);
      chk_span(16, 18);
      chk_span(19, 20);
      chk_span(21, 22);
      chk_span(23, 26);
      chk_span(27, 28);
      chk_span(29, 30);
      chk_span(31, 34);
      chk_span(35, 38);
      chk_span(39, 43);
      chk_span(44, 44);
      chk_span(45, 48);
      chk_span(49, 52);
      chk_span(53, 57);
      chk_span(58, 58);
      chk_span(59, 61);
      chk_span(62, 63);
      chk_val(query_reads_reg, 16'h0040, "query read count");
      chk_val(last_addr_reg, TBL_LAST, "last query address");
      // Narrow widths refused, then wide addresses beyond the table
      for (int i = 0; i < 8; i++)
         if (i < 4)
            fqt_host_model_i.reqs[i] = '{1'b1, (i % 2) ? WID_BYTE8 : WID_HALF16, 19'(i + 16)};
         else
            fqt_host_model_i.reqs[i] = '{1'b1, WID_WORD32, 19'($urandom_range(19'h7ffff, 64))};
      fqt_host_model_i.burst(8);
      for (int i = 0; i < 8; i++)
         chk_rsp(fqt_host_model_i.rsps[i], i < 4, 32'h0);
      chk_val(width_err_reg, 1, "width error set");
      fqt_host_model_i.clear_err();
      chk_val(width_err_reg, 0, "width error cleared");
      // Clear and refusal in one cycle: the refusal must stick
      fqt_host_model_i.reqs[0] = '{1'b1, WID_BYTE8, 19'h00020};
      fork
         fqt_host_model_i.clear_err();
         fqt_host_model_i.burst(1);
      join
      chk_rsp(fqt_host_model_i.rsps[0], 1'b1, 32'h00000000);
      chk_val(width_err_reg, 1, "width error kept over clear");
      fqt_host_model_i.send_cmd(8'($urandom_range(151)));
      chk_val(query_mode_reg, 1, "mode after unknown command");
      fqt_host_model_i.send_cmd(CMD_READ_ARRAY);
      chk_val(query_mode_reg, 0, "array mode");
      array_burst(4);
      fqt_host_model_i.send_cmd(CMD_QUERY);
      @(negedge clock);
      rst_b = 1'b0;
      @(negedge clock);
      rst_b = 1'b1;
      chk_val(query_mode_reg, 0, "mode after second reset");
      chk_val(width_err_reg, 0, "width error after second reset");
      chk_val(query_reads_reg, 16'h0000, "read count after second reset");
      tally_and_finish();
   end
endmodule

bind fqt_query_top fqt_query_monitor fqt_query_monitor_i (.clock, .rst_b, .cmd_in, .rd_req,
   .array_data, .err_clear, .rd_rsp_reg, .query_mode_reg, .width_err_reg, .last_addr_reg,
   .query_reads_reg);
